// *** core/adcs_pkg.sv ***
// Shared constants, register map and types of the conversion sequencer.
package adcs_pkg;

  // Fixed counts of the converter module.
  localparam int SLOT_W = 4;
  localparam int NSLOT  = 16;
  localparam int NIRQ   = 4;
  localparam int NPPB   = 4;
  localparam int RES_W  = 16;
  localparam int TS_W   = 16;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SWF    = 8'h04;
  localparam logic [7:0] REG_BURST  = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C;
  localparam logic [7:0] REG_IRQSEL = 8'h10;
  localparam logic [7:0] REG_IRQFLG = 8'h14;
  localparam logic [1:0] BLK_MISC   = 2'h0;
  localparam logic [1:0] BLK_SLOT   = 2'h1;
  localparam logic [1:0] BLK_RES    = 2'h2;
  localparam logic [1:0] BLK_PPB    = 2'h3;
  localparam logic [1:0] PPB_CFG    = 2'h0;
  localparam logic [1:0] PPB_OFS    = 2'h1;
  localparam logic [1:0] PPB_LIM    = 2'h2;

  // Trigger source codes of a slot or of the burst trigger.
  localparam logic [4:0] TRG_TMR_A  = 5'h01;
  localparam logic [4:0] TRG_TMR_B  = 5'h04;
  localparam logic [4:0] TRG_EXT    = 5'h07;
  localparam logic [4:0] TRG_PWM    = 5'h08;
  localparam logic [1:0] ITRG_FIRST  = 2'h1;
  localparam logic [1:0] ITRG_SECOND = 2'h2;

  // Values after reset and masks.
  localparam logic [9:0]  CTRL_RST    = 10'h000;
  localparam logic [15:0] NARROW_MASK = 16'h0FFF;
  localparam logic [8:0]  ACQ_DONE    = 9'h000;

  typedef enum logic [1:0] {
    PRIO_RR    = 2'b00,
    PRIO_HP    = 2'b01,
    PRIO_BURST = 2'b10
  } adcs_prio_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ACQ   = 2'b01,
    ST_CONV  = 2'b10,
    ST_WRITE = 2'b11
  } adcs_state_t;

  typedef struct packed {
    logic [4:0] hp_cnt;
    adcs_prio_t mode;
    logic       wide;
    logic       eoc_start;
    logic       en;
  } adcs_ctrl_t;

  typedef struct packed {
    logic [1:0] itrig;
    logic [8:0] acq;
    logic [4:0] chan;
    logic [4:0] trig;
  } adcs_slot_t;

  typedef struct packed {
    logic              irq_en;
    logic              trip_en;
    logic [SLOT_W-1:0] slot;
  } adcs_ppb_cfg_t;

  typedef struct packed {
    logic       sample;
    logic       start;
    logic       wide;
    logic [4:0] chan;
  } adcs_core_req_t;

endpackage

// *** core/adcs_res_mem.sv ***
// Result storage, one word per conversion slot, registered read.
`timescale 1ns/1ps
module adcs_res_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);

  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule

// *** core/adcs_ppb.sv ***
// Post-processing block: offset, error, limits, zero crossing, delay.
`timescale 1ns/1ps
module adcs_ppb (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Settings
  input  adcs_pkg::adcs_ppb_cfg_t    cfg,
  input  wire logic signed [15:0]    offset,
  input  wire logic signed [15:0]    setpt,
  input  wire logic signed [15:0]    lim_hi,
  input  wire logic signed [15:0]    lim_lo,
  // Result being written
  input  wire logic                  res_vld,
  input  wire logic [3:0]            res_slot,
  input  wire logic signed [15:0]    raw,
  // Sampling start
  input  wire logic                  smp_vld,
  input  wire logic [3:0]            smp_slot,
  input  wire logic [15:0]           smp_dly,
  // Outputs
  output logic                       link,
  output logic signed [15:0]         corr,
  output logic signed [15:0]         err_q,
  output logic [15:0]                dly_q,
  output logic                       evt_q
);

  logic signed [15:0] err_d;
  logic [15:0]        dly_d;
  logic               evt_d;
  logic               seen_q;
  logic               seen_d;

  always_comb begin
    link   = res_slot == cfg.slot;
    corr   = raw - offset;
    err_d  = err_q;
    dly_d  = dly_q;
    evt_d  = 1'b0;
    seen_d = seen_q;
    if (res_vld && link) begin
      err_d  = corr - setpt;
      // Zero crossing needs one earlier sample to compare signs against.
      evt_d  = (err_d > lim_hi) || (err_d < lim_lo) ||
               (seen_q && (err_d[15] != err_q[15]));
      seen_d = 1'b1;
    end
    if (smp_vld && smp_slot == cfg.slot) begin
      dly_d = smp_dly;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q  <= '0;
      dly_q  <= '0;
      evt_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      err_q  <= err_d;
      dly_q  <= dly_d;
      evt_q  <= evt_d;
      seen_q <= seen_d;
    end
  end

endmodule

// *** core/adcs_top.sv ***
// Conversion sequencer: slots, triggers, arbitration, events, registers.
//
// How it works
// - Each slot holds its own trigger, channel and acquisition window.
// - One trigger pends every slot that selects it; they convert in turn.
// - Slots may share trigger and channel, giving oversampled results.
// - Triggers: timers of both subsystems, pulse modulators, pin, software.
// - Setting of the first or second interrupt flag can trigger slots.
// - Default round robin; pointer moves past each served slot and wraps.
// - High-priority slots pre-empt; round robin resumes where it stopped.
// - High priority covers slots zero upward, as many as configured.
// - Two high-priority slots at once: the lower number goes first.
// - Burst: one trigger pends a programmed number of successive slots.
// - Four interrupt lines, each set by the end of any chosen slot.
// - End pulse at conversion start or one cycle before result write.
// - Four post-processing blocks, each linked to any result.
// - The lowest-numbered linked block removes its offset from the stored result.
// - A linked block computes result minus set-point as an error.
// - Limit or zero-crossing events raise an interrupt and/or a trip.
// - Delay from trigger to sampling start is captured for software.
// - Wide results for differential inputs, twelve bits for single-ended.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module adcs_top #(
  parameter int NPWM = 16
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  // Trigger sources
  input  wire logic [2:0]                    tmr_a_trig,
  input  wire logic [2:0]                    tmr_b_trig,
  input  wire logic [NPWM-1:0]               pwm_trig,
  input  wire logic                          ext_trig_pin,
  // Converter core
  output adcs_pkg::adcs_core_req_t           core_req_q,
  input  wire logic                          core_done,
  input  wire logic [15:0]                   core_data,
  // Events
  output logic      [adcs_pkg::NIRQ-1:0]     irq_lines_q,
  output logic      [adcs_pkg::NPPB-1:0]     ppb_irq_q,
  output logic      [adcs_pkg::NPPB-1:0]     ppb_trip_q
);

  localparam int NS = adcs_pkg::NSLOT;
  localparam int SW = adcs_pkg::SLOT_W;
  localparam int NI = adcs_pkg::NIRQ;
  localparam int NP = adcs_pkg::NPPB;

  // Configuration and events.
  adcs_pkg::adcs_ctrl_t    ctrl_q, ctrl_d;
  adcs_pkg::adcs_slot_t    slot_q [NS];
  adcs_pkg::adcs_slot_t    slot_d [NS];
  adcs_pkg::adcs_ppb_cfg_t pcfg_q [NP];
  adcs_pkg::adcs_ppb_cfg_t pcfg_d [NP];
  logic signed [15:0]      poff_q [NP];
  logic signed [15:0]      poff_d [NP];
  logic signed [15:0]      psp_q  [NP];
  logic signed [15:0]      psp_d  [NP];
  logic signed [15:0]      phi_q  [NP];
  logic signed [15:0]      phi_d  [NP];
  logic signed [15:0]      plo_q  [NP];
  logic signed [15:0]      plo_d  [NP];
  logic [7:0]              irqsel_q [NI];
  logic [7:0]              irqsel_d [NI];
  logic [4:0]              btrig_q, btrig_d;
  logic [SW-1:0]           bsize_q, bsize_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    rdres_q, rdres_d;
  logic [NI-1:0]           irq_d;
  logic [NP-1:0]           pirq_d, ptrip_d;

  // Sequencer.
  adcs_pkg::adcs_state_t   st_q, st_d;
  adcs_pkg::adcs_core_req_t req_d;
  logic [NS-1:0]           pend_q, pend_d, pset, clr, hp;
  logic [15:0]             tstamp_q [NS];
  logic [15:0]             tstamp_d [NS];
  logic [15:0]             ts_q, ts_d, raw_q, raw_d, wr_val;
  logic [SW-1:0]           rr_q, rr_d, cur_q, cur_d, pick, hp_pick, rr_pick;
  logic [8:0]              cnt_q, cnt_d;
  logic [2:0]              ext_s_q, ext_s_d;
  logic                    ext_lvl_q, ext_lvl_d;
  logic [31:0]             src;
  logic [NI-1:0]           irq_set, irq_rise;
  logic                    eoc, go, hpf, bfire;

  // Post-processing block wiring.
  logic [NP-1:0]           link, evt;
  logic signed [15:0]      corr [NP];
  logic signed [15:0]      perr [NP];
  logic [15:0]             pdly [NP];
  logic [15:0]             mem_rdata;

  for (genvar k = 0; k < NP; k++) begin : g_ppb
    adcs_ppb u_ppb (
      .clk      (clk),
      .rst_n    (rst_n),
      .cfg      (pcfg_q[k]),
      .offset   (poff_q[k]),
      .setpt    (psp_q[k]),
      .lim_hi   (phi_q[k]),
      .lim_lo   (plo_q[k]),
      .res_vld  (st_q == adcs_pkg::ST_WRITE),
      .res_slot (cur_q),
      .raw      (raw_q),
      .smp_vld  (go),
      .smp_slot (pick),
      .smp_dly  (ts_q - tstamp_q[pick]),
      .link     (link[k]),
      .corr     (corr[k]),
      .err_q    (perr[k]),
      .dly_q    (pdly[k]),
      .evt_q    (evt[k])
    );
  end

  adcs_res_mem #(.DEPTH(NS), .AW(SW), .W(adcs_pkg::RES_W)) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (st_q == adcs_pkg::ST_WRITE),
    .waddr   (cur_q),
    .wdata   (wr_val),
    .raddr   (reg_addr[5:2]),
    .rdata_q (mem_rdata)
  );

  // Result reads come from the memory's own output register.
  assign reg_rdata = rdres_q ? {16'h0000, mem_rdata} : rdata_q;

  always_comb begin
    logic [SW-1:0] idx;
    logic          hw;
    logic          found;
    idx     = '0;
    hw      = 1'b0;
    found   = 1'b0;
    hpf     = 1'b0;
    hp_pick = '0;
    rr_pick = '0;
    // Only the second and third flip-flops are compared.
    ext_s_d   = {ext_s_q[1:0], ext_trig_pin};
    ext_lvl_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_lvl_q;
    src = '0;
    src[adcs_pkg::TRG_TMR_A +: 3]  = tmr_a_trig;
    src[adcs_pkg::TRG_TMR_B +: 3]  = tmr_b_trig;
    src[adcs_pkg::TRG_EXT]         = ext_s_q[1] & ext_s_q[2] & ~ext_lvl_q;
    src[adcs_pkg::TRG_PWM +: NPWM] = pwm_trig;
    eoc = ctrl_q.eoc_start ?
          (st_q == adcs_pkg::ST_ACQ && cnt_q == adcs_pkg::ACQ_DONE) :
          (st_q == adcs_pkg::ST_CONV && core_done);
    for (int j = 0; j < NI; j++) begin
      irq_set[j] = eoc && irqsel_q[j][7] && irqsel_q[j][SW-1:0] == cur_q;
    end
    irq_rise = irq_set & ~irq_lines_q;
    bfire = ctrl_q.mode == adcs_pkg::PRIO_BURST && src[btrig_q];
    for (int i = 0; i < NS; i++) begin
      hp[i] = ctrl_q.mode == adcs_pkg::PRIO_HP &&
              5'(i) < ctrl_q.hp_cnt;
      hw = src[slot_q[i].trig] ||
           (slot_q[i].itrig == adcs_pkg::ITRG_FIRST && irq_rise[0]) ||
           (slot_q[i].itrig == adcs_pkg::ITRG_SECOND && irq_rise[1]);
      // In burst mode slots answer only to the burst trigger and to software.
      if (ctrl_q.mode == adcs_pkg::PRIO_BURST) begin
        hw = 1'b0;
      end
      pset[i] = hw || (reg_wr && reg_addr == adcs_pkg::REG_SWF &&
                reg_wdata[i]) ||
                (bfire && SW'(SW'(i) - rr_q) <= bsize_q);
    end
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend_q[i] && hp[i]) begin
        hp_pick = SW'(i);
        hpf     = 1'b1;
      end
    end
    for (int k = NS - 1; k >= 0; k--) begin
      idx = rr_q + SW'(k);
      if (pend_q[idx] && !hp[idx]) begin
        rr_pick = idx;
        found   = 1'b1;
      end
    end
    pick = hpf ? hp_pick : rr_pick;
    go   = ctrl_q.en && st_q == adcs_pkg::ST_IDLE && (hpf || found);
    clr   = '0;
    st_d  = st_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    rr_d  = rr_q;
    raw_d = raw_q;
    req_d = core_req_q;
    case (st_q)
      adcs_pkg::ST_IDLE: begin
        if (go) begin
          clr[pick]    = 1'b1;
          cur_d        = pick;
          cnt_d        = slot_q[pick].acq;
          req_d.sample = 1'b1;
          req_d.chan   = slot_q[pick].chan;
          st_d         = adcs_pkg::ST_ACQ;
          if (!hpf) begin
            rr_d = pick + 4'h1;
          end
        end
      end
      adcs_pkg::ST_ACQ: begin
        if (cnt_q == adcs_pkg::ACQ_DONE) begin
          req_d.sample = 1'b0;
          req_d.start  = 1'b1;
          st_d         = adcs_pkg::ST_CONV;
        end else begin
          cnt_d = cnt_q - 9'h001;
        end
      end
      adcs_pkg::ST_CONV: begin
        req_d.start = 1'b0;
        if (core_done) begin
          raw_d = ctrl_q.wide ? core_data :
                  (core_data & adcs_pkg::NARROW_MASK);
          st_d  = adcs_pkg::ST_WRITE;
        end
      end
      adcs_pkg::ST_WRITE: begin
        st_d = adcs_pkg::ST_IDLE;
      end
      default: begin
        st_d = adcs_pkg::ST_IDLE;
      end
    endcase
    req_d.wide = ctrl_q.wide;
    // A trigger in the cycle its slot starts stays pending.
    pend_d = (pend_q & ~clr) | pset;
    for (int i = 0; i < NS; i++) begin
      tstamp_d[i] = (pset[i] && (!pend_q[i] || clr[i])) ? ts_q : tstamp_q[i];
    end
    ts_d   = ts_q + 16'h0001;
    wr_val = raw_q;
    for (int k = NP - 1; k >= 0; k--) begin
      if (link[k]) begin
        wr_val = corr[k];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q       <= adcs_pkg::ST_IDLE;
      core_req_q <= '0;
      pend_q     <= '0;
      tstamp_q   <= '{default: '0};
      ts_q       <= '0;
      rr_q       <= '0;
      cur_q      <= '0;
      cnt_q      <= '0;
      raw_q      <= '0;
      ext_s_q    <= '0;
      ext_lvl_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      core_req_q <= req_d;
      pend_q     <= pend_d;
      tstamp_q   <= tstamp_d;
      ts_q       <= ts_d;
      rr_q       <= rr_d;
      cur_q      <= cur_d;
      cnt_q      <= cnt_d;
      raw_q      <= raw_d;
      ext_s_q    <= ext_s_d;
      ext_lvl_q  <= ext_lvl_d;
    end
  end

  always_comb begin
    ctrl_d   = ctrl_q;
    slot_d   = slot_q;
    pcfg_d   = pcfg_q;
    poff_d   = poff_q;
    psp_d    = psp_q;
    phi_d    = phi_q;
    plo_d    = plo_q;
    irqsel_d = irqsel_q;
    btrig_d  = btrig_q;
    bsize_d  = bsize_q;
    rdata_d  = '0;
    rdres_d  = reg_rd && reg_addr[7:6] == adcs_pkg::BLK_RES;
    irq_d    = irq_lines_q;
    pirq_d   = ppb_irq_q;
    if (reg_wr) begin
      case (reg_addr[7:6])
        adcs_pkg::BLK_MISC: begin
          case (reg_addr)
            adcs_pkg::REG_CTRL: ctrl_d = adcs_pkg::adcs_ctrl_t'(reg_wdata[9:0]);
            adcs_pkg::REG_BURST: begin
              btrig_d = reg_wdata[4:0];
              bsize_d = reg_wdata[11:8];
            end
            adcs_pkg::REG_IRQSEL: begin
              for (int j = 0; j < NI; j++) begin
                irqsel_d[j] = reg_wdata[8*j +: 8];
              end
            end
            adcs_pkg::REG_IRQFLG: begin
              irq_d  = irq_lines_q & ~reg_wdata[NI-1:0];
              pirq_d = ppb_irq_q & ~reg_wdata[NI +: NP];
            end
            default: ;
          endcase
        end
        adcs_pkg::BLK_SLOT: begin
          slot_d[reg_addr[5:2]] = adcs_pkg::adcs_slot_t'(reg_wdata[20:0]);
        end
        adcs_pkg::BLK_PPB: begin
          case (reg_addr[3:2])
            adcs_pkg::PPB_CFG: begin
              pcfg_d[reg_addr[5:4]] = adcs_pkg::adcs_ppb_cfg_t'(reg_wdata[5:0]);
            end
            adcs_pkg::PPB_OFS: begin
              poff_d[reg_addr[5:4]] = reg_wdata[15:0];
              psp_d[reg_addr[5:4]]  = reg_wdata[31:16];
            end
            adcs_pkg::PPB_LIM: begin
              phi_d[reg_addr[5:4]] = reg_wdata[15:0];
              plo_d[reg_addr[5:4]] = reg_wdata[31:16];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // Hardware sets win over a clear in the same cycle.
    irq_d = irq_d | irq_set;
    for (int k = 0; k < NP; k++) begin
      pirq_d[k]  = pirq_d[k] | (evt[k] & pcfg_q[k].irq_en);
      ptrip_d[k] = evt[k] & pcfg_q[k].trip_en;
    end
    if (reg_rd) begin
      case (reg_addr[7:6])
        adcs_pkg::BLK_MISC: begin
          case (reg_addr)
            adcs_pkg::REG_CTRL:   rdata_d = {22'h000000, ctrl_q};
            adcs_pkg::REG_BURST:  rdata_d = {20'h00000, bsize_q, 3'h0, btrig_q};
            adcs_pkg::REG_STAT:   rdata_d = {7'h00, st_q != adcs_pkg::ST_IDLE,
                                             cur_q, rr_q, pend_q};
            adcs_pkg::REG_IRQSEL: begin
              for (int j = 0; j < NI; j++) begin
                rdata_d[8*j +: 8] = irqsel_q[j];
              end
            end
            adcs_pkg::REG_IRQFLG: rdata_d = {24'h000000, ppb_irq_q, irq_lines_q};
            default: ;
          endcase
        end
        adcs_pkg::BLK_SLOT: rdata_d = {11'h000, slot_q[reg_addr[5:2]]};
        adcs_pkg::BLK_PPB: begin
          case (reg_addr[3:2])
            adcs_pkg::PPB_CFG: rdata_d = {26'h0000000, pcfg_q[reg_addr[5:4]]};
            adcs_pkg::PPB_OFS: rdata_d = {psp_q[reg_addr[5:4]],
                                          poff_q[reg_addr[5:4]]};
            adcs_pkg::PPB_LIM: rdata_d = {plo_q[reg_addr[5:4]],
                                          phi_q[reg_addr[5:4]]};
            default: rdata_d = {perr[reg_addr[5:4]], pdly[reg_addr[5:4]]};
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q      <= adcs_pkg::adcs_ctrl_t'(adcs_pkg::CTRL_RST);
      slot_q      <= '{default: '0};
      pcfg_q      <= '{default: '0};
      poff_q      <= '{default: '0};
      psp_q       <= '{default: '0};
      phi_q       <= '{default: '0};
      plo_q       <= '{default: '0};
      irqsel_q    <= '{default: '0};
      btrig_q     <= '0;
      bsize_q     <= '0;
      rdata_q     <= '0;
      rdres_q     <= 1'b0;
      irq_lines_q <= '0;
      ppb_irq_q   <= '0;
      ppb_trip_q  <= '0;
    end else begin
      ctrl_q      <= ctrl_d;
      slot_q      <= slot_d;
      pcfg_q      <= pcfg_d;
      poff_q      <= poff_d;
      psp_q       <= psp_d;
      phi_q       <= phi_d;
      plo_q       <= plo_d;
      irqsel_q    <= irqsel_d;
      btrig_q     <= btrig_d;
      bsize_q     <= bsize_d;
      rdata_q     <= rdata_d;
      rdres_q     <= rdres_d;
      irq_lines_q <= irq_d;
      ppb_irq_q   <= pirq_d;
      ppb_trip_q  <= ptrip_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pend_clear;
    go && !pset[pick] |=> !pend_q[cur_q];
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("started slot still pending");
  property p_acq_end;
    $fell(core_req_q.sample) |-> core_req_q.start &&
      $past(cnt_q) == adcs_pkg::ACQ_DONE;
  endproperty
  a_acq_end: assert property (p_acq_end)
    else $error("acquisition ended early");
  property p_rr_adv;
    go && !hpf |=> rr_q == cur_q + 4'h1;
  endproperty
  a_rr_adv: assert property (p_rr_adv)
    else $error("round robin pointer wrong");
  property p_hp_keep;
    go && hpf |=> rr_q == $past(rr_q);
  endproperty
  a_hp_keep: assert property (p_hp_keep)
    else $error("pre-emption moved pointer");
  property p_hp_low;
    go && hpf && pend_q[0] |=> cur_q == 4'h0;
  endproperty
  a_hp_low: assert property (p_hp_low)
    else $error("lower high slot skipped");
  property p_burst;
    bfire |=> pend_q[$past(rr_q)];
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst did not pend slot");
  property p_irq;
    irq_set[0] |=> irq_lines_q[0];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line not set");
  property p_eoc_end;
    eoc && !ctrl_q.eoc_start |=> st_q == adcs_pkg::ST_WRITE;
  endproperty
  a_eoc_end: assert property (p_eoc_end)
    else $error("late end pulse misplaced");
  property p_one_start;
    core_req_q.start |=> !core_req_q.start ##1 !core_req_q.start;
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("overlapping conversions");

  c_burst: cover property (bfire ##[1:40] st_q == adcs_pkg::ST_WRITE);
  c_preempt: cover property (go && hpf && pend_q != clr);
  c_irq: cover property (irq_set[0] ##[1:60] irq_rise[1]);

endmodule

// *** sim/adcs_core_model.sv ***
// Behavioural converter core that answers start pulses after a set delay.
`timescale 1ns/1ps
module adcs_core_model (
  // Clock
  input  wire logic              clk,
  // Requests and answer delay
  input  adcs_pkg::adcs_core_req_t req,
  input  wire logic [3:0]        lat,
  // Answer
  output logic                   done,
  output logic [15:0]            data
);
  logic [3:0] cnt = 4'h0;
  logic [4:0] ch  = 5'h00;
  initial done = 1'b0;
  initial data = 16'h0000;
  // Data toggles outside the answer cycle so a stale value is never read.
  always @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        done <= 1'b1;
        data <= {4'hF, 7'h00, ch};
      end
    end else if (req.start) begin
      cnt <= lat;
      ch  <= req.chan;
    end
  end
endmodule

// *** sim/adcs_top_tb_top.sv ***
// Testbench of the conversion sequencer with a converter core model.
`timescale 1ns/1ps
module adcs_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, done;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [2:0] tma = 3'h0;
  logic [3:0] lat = 4'h2, irq;
  logic [15:0] cdat;
  adcs_pkg::adcs_core_req_t req;
  int bad_count = 0, samples_checked = 0;
  always #20 clk = ~clk;
  adcs_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .tmr_a_trig(tma), .tmr_b_trig(3'h0), .pwm_trig(16'h0000),
    .ext_trig_pin(1'b0), .core_req_q(req), .core_done(done),
    .core_data(cdat), .irq_lines_q(irq), .ppb_irq_q(), .ppb_trip_q());
  adcs_core_model core (.clk(clk), .req(req), .lat(lat), .done(done),
    .data(cdat));
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wrr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    addr <= a; wd <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  // Polls status until nothing is pending and the core path is free.
  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      rdr(adcs_pkg::REG_STAT, d);
      if (d[24] === 1'b0 && d[15:0] === 16'h0000) break;
    end
  endtask
  task automatic t_reset;
    rdr(adcs_pkg::REG_CTRL, d);
    chk("ctrl", d, 32'h0);
    rdr(8'h3C, d);
    chk("unmapped", d, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_seq;
    wrr(adcs_pkg::REG_CTRL, 32'h1);
    wrr(8'h40, 32'h0A0);
    wrr(8'h44, 32'h120);
    wrr(adcs_pkg::REG_SWF, 32'h3);
    wait_idle();
    rdr(8'h80, d);
    chk("res0", d, 32'h5);
    rdr(8'h84, d);
    chk("res1", d, 32'h9);
    $display("sequence test done");
  endtask
  task automatic t_timer;
    lat <= 4'h9;
    wrr(adcs_pkg::REG_CTRL, 32'h5);
    wrr(adcs_pkg::REG_IRQSEL, 32'h82);
    wrr(8'h48, 32'h0E1);
    @(posedge clk);
    tma <= 3'h1;
    @(posedge clk);
    tma <= 3'h0;
    wait_idle();
    rdr(8'h88, d);
    chk("res2", d, 32'hF007);
    chk("irq0", {28'h0, irq}, 32'h1);
    wrr(adcs_pkg::REG_IRQFLG, 32'h1);
    rdr(adcs_pkg::REG_IRQFLG, d);
    chk("irqflg", d, 32'h0);
    $display("timer test done");
  endtask
  task automatic t_ofs;
    lat <= 4'h1;
    wrr(adcs_pkg::REG_CTRL, 32'h1);
    wrr(8'hC0, 32'h3);
    wrr(8'hC4, 32'h5);
    wrr(8'h4C, 32'h180);
    wrr(adcs_pkg::REG_SWF, 32'h8);
    wait_idle();
    rdr(8'h8C, d);
    chk("res3", d, 32'h7);
    $display("offset test done");
  endtask
  // Slot 0 is high priority and must pre-empt the round robin pick of slot 1.
  task automatic t_hp;
    wrr(adcs_pkg::REG_CTRL, 32'h2B);
    wrr(adcs_pkg::REG_IRQSEL, 32'h81);
    wrr(8'hD0, 32'h30);
    wrr(adcs_pkg::REG_SWF, 32'h3);
    wait_idle();
    chk("stat", d, 32'h00120000);
    rdr(adcs_pkg::REG_IRQFLG, d);
    chk("flags", d, 32'h21);
    rdr(8'hDC, d);
    chk("err_dly", d, 32'h00050001);
    rdr(8'h84, d);
    chk("res1_hp", d, 32'h9);
    $display("priority test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_seq();
    t_timer();
    t_ofs();
    t_hp();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule
